// ---- addunit_pkg.sv ----
`default_nettype none
package addunit_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACCF = 8'h08;
  localparam logic [7:0] OFS_BC = 8'h0c;
  localparam logic [7:0] OFS_DE = 8'h10;
  localparam logic [7:0] OFS_POINTER = 8'h14;
  localparam logic [7:0] OFS_FIRST_IDX = 8'h18;
  localparam logic [7:0] OFS_SECOND_IDX = 8'h1c;
  localparam logic [7:0] OFS_PC = 8'h20;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD = 1;
  localparam logic [7:0] OP_ADD_IMM = 8'hc6;
  localparam logic [7:0] OP_ADC_IMM = 8'hce;
  localparam logic [7:0] OP_ADD_MEM = 8'h86;
  localparam logic [7:0] OP_ADC_MEM = 8'h8e;
  localparam logic [7:0] PFX_FIRST = 8'hdd;
  localparam logic [7:0] PFX_SECOND = 8'hfd;
  localparam logic [3:0] OP_GROUP = 4'h8;
  localparam int OP_CARRY_BIT = 3;
  localparam logic [2:0] R_B = 3'h0;
  localparam logic [2:0] R_C = 3'h1;
  localparam logic [2:0] R_D = 3'h2;
  localparam logic [2:0] R_E = 3'h3;
  localparam logic [2:0] R_H = 3'h4;
  localparam logic [2:0] R_L = 3'h5;
  localparam logic [2:0] R_MEM = 3'h6;
  localparam logic [2:0] R_ACC = 3'h7;
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  localparam logic [2:0] T_OPFETCH = 3'h4;
  localparam logic [2:0] T_READ = 3'h3;
  localparam logic [2:0] T_CALC = 3'h5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_FETCH2 = 3'b010,
    ST_IMM = 3'b011,
    ST_DISP = 3'b100,
    ST_CALC = 3'b101,
    ST_MEM = 3'b110
  } state_t;
endpackage : addunit_pkg
`default_nettype wire

// ---- add_adc_unit.sv ----
// How it works
// - Register field: A=111, B..L=000..101.
// - Add register: one 4-state machine cycle.
// - Immediate add: fetch next byte, 4+3.
// - Unprefixed memory add via pointer pair, 4+3.
// - First prefix: first index plus signed displacement.
// - Second prefix: second index plus displacement.
// - Indexed add: 4,4,3,5,3 states, sum stored.
// - Sign flag follows result bit 7.
// - Zero flag set when result is zero.
// - Half carry from bit 3.
// - Overflow flag on signed overflow; subtract cleared.
// - Carry flag from bit 7.
// - Carry-add adds carry, same forms, timing.
// - Carry-add encodings mirror plain add.
`default_nettype none
module add_adc_unit
  import addunit_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [7:0] RD_DATA_IN,
  output logic [15:0] BUS_ADDR_OUT,
  output logic BUS_RD_OUT,
  output logic FETCH_OUT,
  output logic BUSY_OUT
);
  // Offsets run up to 8'h20, so six address bits are the least.
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must lie between 6 and 8.");
  end

  state_t state, next_state;
  logic [2:0] tcnt, next_tcnt, tlen;
  logic [7:0] acc, next_acc, flags, next_flags;
  logic [7:0] gp [0:5];
  logic [7:0] next_gp [0:5];
  logic [15:0] first_idx, next_first_idx, second_idx, next_second_idx;
  logic [15:0] pc, next_pc;
  logic [15:0] addr, next_addr;
  logic [7:0] disp, next_disp;
  logic is_adc, next_is_adc, use_second, next_use_second;
  logic bad, next_bad;
  logic [31:0] prdata, next_prdata;
  logic pslverr, next_pslverr;
  logic last_t, idle, setup, wr;
  logic [7:0] paddr8;

  // Both operations share one adder; carry-in is zero for plain add.
  function automatic logic [15:0] alu(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin,
                                      input logic [7:0] fin);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] f;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    f = fin;
    f[FLAG_S] = sum[7];
    f[FLAG_Z] = (sum[7:0] == 8'h00);
    f[FLAG_H] = low[4];
    f[FLAG_PV] = (a[7] == b[7]) && (sum[7] != a[7]);
    f[FLAG_N] = 1'b0;
    f[FLAG_C] = sum[8];
    alu = {f, sum[7:0]};
  endfunction : alu

  // Code 110 never reaches this; it becomes a memory read instead.
  function automatic logic [7:0] sel_reg(input logic [2:0] r,
                                         input logic [7:0] a,
                                         input logic [7:0] b_,
                                         input logic [7:0] c_,
                                         input logic [7:0] d_,
                                         input logic [7:0] e_,
                                         input logic [7:0] h_,
                                         input logic [7:0] l_);
    case (r)
      R_B: sel_reg = b_;
      R_C: sel_reg = c_;
      R_D: sel_reg = d_;
      R_E: sel_reg = e_;
      R_H: sel_reg = h_;
      R_L: sel_reg = l_;
      R_ACC: sel_reg = a;
      default: sel_reg = 8'h00;
    endcase
  endfunction : sel_reg

  assign paddr8 = 8'(PADDR_IN);
  assign idle = (state == ST_IDLE);
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign PREADY_OUT = PSEL_IN && PENABLE_IN;
  assign PRDATA_OUT = prdata;
  assign PSLVERR_OUT = pslverr;
  assign BUS_ADDR_OUT = addr;
  assign BUS_RD_OUT = !idle && (state != ST_CALC);
  assign FETCH_OUT = (state == ST_FETCH) || (state == ST_FETCH2);
  assign BUSY_OUT = !idle;

  always_comb begin
    case (state)
      ST_FETCH, ST_FETCH2: tlen = T_OPFETCH;
      ST_CALC: tlen = T_CALC;
      default: tlen = T_READ;
    endcase
    last_t = (tcnt == tlen - 3'h1);
  end

  always_comb begin
    logic [15:0] res;
    logic cin;
    logic [15:0] base;
    res = 16'h0000;
    cin = 1'b0;
    base = 16'h0000;
    next_state = state;
    next_tcnt = tcnt;
    next_acc = acc;
    next_flags = flags;
    next_gp = gp;
    next_first_idx = first_idx;
    next_second_idx = second_idx;
    next_pc = pc;
    next_addr = addr;
    next_disp = disp;
    next_is_adc = is_adc;
    next_use_second = use_second;
    next_bad = bad;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    // Read data is captured in setup so the access phase needs no wait.
    if (setup) begin
      next_prdata = 32'h0000_0000;
      case (paddr8)
        OFS_CTRL: next_prdata = 32'h0000_0000;
        OFS_STATUS: begin
          next_prdata[STAT_BUSY] = !idle;
          next_prdata[STAT_BAD] = bad;
        end
        OFS_ACCF: next_prdata = {16'h0000, flags, acc};
        OFS_BC: next_prdata = {16'h0000, gp[0], gp[1]};
        OFS_DE: next_prdata = {16'h0000, gp[2], gp[3]};
        OFS_POINTER: next_prdata = {16'h0000, gp[4], gp[5]};
        OFS_FIRST_IDX: next_prdata = {16'h0000, first_idx};
        OFS_SECOND_IDX: next_prdata = {16'h0000, second_idx};
        OFS_PC: next_prdata = {16'h0000, pc};
        default: next_pslverr = 1'b1;
      endcase
    end else begin
      // The error lasts only for the access cycle that it answers.
      next_pslverr = 1'b0;
    end
    // Register writes, except the STATUS bad clear, are ignored while an instruction runs.
    if (wr && idle) begin
      case (paddr8)
        OFS_CTRL: begin
          if (PWDATA_IN[CTRL_START]) begin
            next_state = ST_FETCH;
            next_tcnt = 3'h0;
            next_addr = pc;
          end
        end
        OFS_ACCF: begin
          next_acc = PWDATA_IN[7:0];
          next_flags = PWDATA_IN[15:8];
        end
        OFS_BC: {next_gp[0], next_gp[1]} = PWDATA_IN[15:0];
        OFS_DE: {next_gp[2], next_gp[3]} = PWDATA_IN[15:0];
        OFS_POINTER: {next_gp[4], next_gp[5]} = PWDATA_IN[15:0];
        OFS_FIRST_IDX: next_first_idx = PWDATA_IN[15:0];
        OFS_SECOND_IDX: next_second_idx = PWDATA_IN[15:0];
        OFS_PC: next_pc = PWDATA_IN[15:0];
        default: ;
      endcase
    end
    if (wr && paddr8 == OFS_STATUS && PWDATA_IN[STAT_BAD]) begin
      next_bad = 1'b0;
    end
    if (!idle) begin
      next_tcnt = tcnt + 3'h1;
    end
    if (!idle && last_t) begin
      next_tcnt = 3'h0;
      cin = is_adc && flags[FLAG_C];
      case (state)
        ST_FETCH: begin
          next_pc = pc + 16'h0001;
          next_addr = pc + 16'h0001;
          next_is_adc = RD_DATA_IN[OP_CARRY_BIT];
          cin = RD_DATA_IN[OP_CARRY_BIT] && flags[FLAG_C];
          if (RD_DATA_IN == PFX_FIRST || RD_DATA_IN == PFX_SECOND) begin
            next_use_second = (RD_DATA_IN == PFX_SECOND);
            next_state = ST_FETCH2;
          end else if (RD_DATA_IN == OP_ADD_IMM ||
                       RD_DATA_IN == OP_ADC_IMM) begin
            next_state = ST_IMM;
          end else if (RD_DATA_IN[7:4] == OP_GROUP) begin
            if (RD_DATA_IN[2:0] == R_MEM) begin
              next_addr = {gp[4], gp[5]};
              next_state = ST_MEM;
            end else begin
              res = alu(acc, sel_reg(RD_DATA_IN[2:0], acc, gp[0], gp[1],
                        gp[2], gp[3], gp[4], gp[5]), cin, flags);
              {next_flags, next_acc} = res;
              next_state = ST_IDLE;
            end
          end else begin
            next_bad = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_FETCH2: begin
          next_pc = pc + 16'h0001;
          next_addr = pc + 16'h0001;
          next_is_adc = RD_DATA_IN[OP_CARRY_BIT];
          if (RD_DATA_IN == OP_ADD_MEM || RD_DATA_IN == OP_ADC_MEM) begin
            next_state = ST_DISP;
          end else begin
            next_bad = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_IMM: begin
          next_pc = pc + 16'h0001;
          res = alu(acc, RD_DATA_IN, cin, flags);
          {next_flags, next_acc} = res;
          next_state = ST_IDLE;
        end
        ST_DISP: begin
          next_pc = pc + 16'h0001;
          next_disp = RD_DATA_IN;
          next_state = ST_CALC;
        end
        ST_CALC: begin
          base = use_second ? second_idx : first_idx;
          next_addr = base + {{8{disp[7]}}, disp};
          next_state = ST_MEM;
        end
        ST_MEM: begin
          res = alu(acc, RD_DATA_IN, cin, flags);
          {next_flags, next_acc} = res;
          next_state = ST_IDLE;
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Pointer and index registers change only through the bus.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state <= ST_IDLE;
      tcnt <= 3'h0;
      acc <= RST_BYTE;
      flags <= RST_BYTE;
      for (int i = 0; i < 6; i++) begin
        gp[i] <= RST_BYTE;
      end
      first_idx <= RST_WORD;
      second_idx <= RST_WORD;
      pc <= RST_WORD;
      addr <= RST_WORD;
      disp <= RST_BYTE;
      is_adc <= 1'b0;
      use_second <= 1'b0;
      bad <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      acc <= next_acc;
      flags <= next_flags;
      gp <= next_gp;
      first_idx <= next_first_idx;
      second_idx <= next_second_idx;
      pc <= next_pc;
      addr <= next_addr;
      disp <= next_disp;
      is_adc <= next_is_adc;
      use_second <= next_use_second;
      bad <= next_bad;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
endmodule : add_adc_unit
`default_nettype wire

// ---- add_adc_unit_sva.sv ----
`default_nettype none
module add_adc_unit_sva
  import addunit_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [7:0] RD_DATA_IN,
  input wire logic [15:0] BUS_ADDR_OUT,
  input wire logic BUS_RD_OUT,
  input wire logic FETCH_OUT,
  input wire logic BUSY_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  zero_wait_a: assert property (PREADY_OUT == (PSEL_IN && PENABLE_IN))
    else $error("pready not zero wait");
  start_a: assert property (PSEL_IN && PENABLE_IN && PWRITE_IN &&
    PADDR_IN == OFS_CTRL && PWDATA_IN[CTRL_START] && !BUSY_OUT
    |=> BUSY_OUT && FETCH_OUT) else $error("start not taken");
  first_fetch_a: assert property ($rose(BUSY_OUT) |->
    FETCH_OUT[*4]) else $error("first fetch not four states");
  busy_bound_a: assert property ($rose(BUSY_OUT) |->
    BUSY_OUT[*4] ##[1:16] !BUSY_OUT) else $error("busy length wrong");
  // A compute cycle is the only busy stretch without a bus read.
  compute_seq_a: assert property (BUSY_OUT &&
    !BUS_RD_OUT && $past(BUS_RD_OUT) |-> (BUSY_OUT && !BUS_RD_OUT)[*5] ##1
    BUS_RD_OUT[*3] ##1 !BUSY_OUT) else $error("indexed tail wrong");
  fetch_read_a: assert property (FETCH_OUT |-> BUS_RD_OUT && BUSY_OUT)
    else $error("fetch without read");
  idle_quiet_a: assert property (!BUSY_OUT |-> !BUS_RD_OUT && !FETCH_OUT)
    else $error("bus active while idle");
  err_map_a: assert property (PSEL_IN && PENABLE_IN && PADDR_IN[1:0] == 0
    |-> PSLVERR_OUT == (PADDR_IN > OFS_PC)) else $error("slverr map wrong");
  err_phase_a: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("slverr outside access");
endmodule : add_adc_unit_sva
bind add_adc_unit add_adc_unit_sva #(.ADDR_W(ADDR_W)) u_add_adc_unit_sva (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .RD_DATA_IN(RD_DATA_IN),
  .BUS_ADDR_OUT(BUS_ADDR_OUT), .BUS_RD_OUT(BUS_RD_OUT),
  .FETCH_OUT(FETCH_OUT), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ---- add_mem_model.sv ----
`default_nettype none
module add_mem_model (
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] junk = 8'h5a;
  // Data toggles outside reads, so a sample at the wrong time cannot pass.
  always @(posedge clk_in) junk <= ~junk;
  assign data_out = rd_in ? mem[addr_in] : junk;
endmodule : add_mem_model
`default_nettype wire

// ---- test_add_adc_unit.sv ----
`default_nettype none
module test_add_adc_unit;
  import addunit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 0, acc, f0, rdd;
  logic [31:0] pwd = 0, prd, rdat;
  logic prdy, perr, rerr, brd, fet, busy;
  logic [15:0] baddr;
  int failures = 0, comparisons = 0;
  always #4 clk = ~clk;
  add_adc_unit u_add_adc_unit (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .RD_DATA_IN(rdd), .BUS_ADDR_OUT(baddr), .BUS_RD_OUT(brd),
    .FETCH_OUT(fet), .BUSY_OUT(busy));
  add_mem_model u_add_mem_model (.clk_in(clk), .addr_in(baddr),
    .rd_in(brd), .data_out(rdd));
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_done(output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 30) begin
      n++;
      @(negedge clk);
    end
  endtask : wait_done
  function automatic logic [15:0] sum_exp(input logic [7:0] a, b, f,
      input logic c);
    logic [8:0] s;
    s = a + b + c;
    f[FLAG_S] = s[7];
    f[FLAG_Z] = s[7:0] == 8'h00;
    f[FLAG_H] = (a[3:0] + b[3:0] + c) > 15;
    f[FLAG_PV] = a[7] == b[7] && s[7] != a[7];
    f[FLAG_N] = 1'b0;
    f[FLAG_C] = s[8];
    return {f, s[7:0]};
  endfunction : sum_exp
  task automatic exec(input logic [7:0] b0, b1, b2, input int nb, cyc,
      input logic [7:0] src, input logic ad);
    int n;
    logic [15:0] e;
    e = sum_exp(acc, src, f0, ad & f0[FLAG_C]);
    u_add_mem_model.mem[16'h1040] = b0;
    u_add_mem_model.mem[16'h1041] = b1;
    u_add_mem_model.mem[16'h1042] = b2;
    apb(1, OFS_PC, 32'h1040);
    apb(1, OFS_ACCF, {16'h0, f0, acc});
    apb(1, OFS_CTRL, 32'h1);
    wait_done(n);
    check(n, cyc);
    apb(0, OFS_ACCF, 0);
    check(rdat, {16'h0, e});
    apb(0, OFS_PC, 0);
    check(rdat, 32'h1040 + nb);
  endtask : exec
  task automatic t_bad();
    int n;
    apb(0, OFS_ACCF, 0);
    check(rdat, 0);
    u_add_mem_model.mem[16'h1040] = 8'h00;
    apb(1, OFS_PC, 32'h1040);
    apb(1, OFS_CTRL, 32'h1);
    wait_done(n);
    check(n, 4);
    apb(0, OFS_STATUS, 0);
    check(rdat, 32'h2);
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_STATUS, 0);
    check(rdat, 0);
    apb(0, OFS_ACCF, 0);
    check(rdat, 0);
    apb(0, 8'h40, 0);
    check(rdat, 0);
    check({31'h0, rerr}, 32'h1);
  endtask : t_bad
  task automatic t_reg();
    logic [7:0] rv [8];
    apb(1, OFS_BC, 32'h7f80);
    apb(1, OFS_DE, 32'h0f01);
    apb(1, OFS_POINTER, 32'h1280);
    acc = 8'h81;
    f0 = 8'h29;
    rv = '{8'h7f, 8'h80, 8'h0f, 8'h01, 8'h12, 8'h80, 8'h00, 8'h81};
    for (int r = 0; r < 16; r++) begin
      if (r[2:0] != R_MEM) begin
        exec({OP_GROUP, r[3:0]}, 0, 0, 1, 4, rv[r[2:0]],
          r[3]);
      end
    end
  endtask : t_reg
  task automatic t_imm_mem();
    acc = 8'hff;
    f0 = 8'h00;
    exec(OP_ADD_IMM, 8'h01, 0, 2, 7, 8'h01, 0);
    acc = 8'h7f;
    f0 = 8'h01;
    exec(OP_ADC_IMM, 8'h00, 0, 2, 7, 8'h00, 1);
    u_add_mem_model.mem[16'h1280] = 8'h08;
    acc = 8'ha0;
    exec(OP_ADD_MEM, 0, 0, 1, 7, 8'h08, 0);
    exec(OP_ADC_MEM, 0, 0, 1, 7, 8'h08, 1);
  endtask : t_imm_mem
  task automatic t_idx();
    logic [7:0] ofs [5];
    logic [15:0] val [5];
    ofs = '{OFS_BC, OFS_DE, OFS_POINTER, OFS_FIRST_IDX, OFS_SECOND_IDX};
    val = '{16'h7f80, 16'h0f01, 16'h1280, 16'h1000, 16'h2000};
    apb(1, OFS_FIRST_IDX, 32'h1000);
    apb(1, OFS_SECOND_IDX, 32'h2000);
    u_add_mem_model.mem[16'h0ffd] = 8'h22;
    u_add_mem_model.mem[16'h2005] = 8'h80;
    acc = 8'h91;
    f0 = 8'h01;
    exec(PFX_FIRST, OP_ADD_MEM, 8'hfd, 3, 19, 8'h22, 0);
    exec(PFX_FIRST, OP_ADC_MEM, 8'hfd, 3, 19, 8'h22, 1);
    exec(PFX_SECOND, OP_ADD_MEM, 8'h05, 3, 19, 8'h80, 0);
    exec(PFX_SECOND, OP_ADC_MEM, 8'h05, 3, 19, 8'h80, 1);
    for (int i = 0; i < 5; i++) begin
      apb(0, ofs[i], 0);
      check(rdat, {16'h0, val[i]});
    end
  endtask : t_idx
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_bad();
    t_reg();
    t_imm_mem();
    t_idx();
    test_done();
  end
  // Generous against roughly six hundred cycles of expected traffic.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : test_add_adc_unit
`default_nettype wire
